// ---- vsscc_cfg.svh ----
// constants of the sync, fast-switch and transient improvement configuration bank
// Behaviour
// - vertical-blank stop line changes only when its upper byte is written
// - a programmed stop line survives standard changes until reset
// - stop line defaults to line 21 (525-line) or 23 (625-line)
// - signed 8-bit offset moves embedded F and V lines, standard inputs only
// - signed 8-bit offset moves F relative to V, standard inputs only
// - switch input sampled on sampling-clock rise (bit 0) or fall (bit 1)
// - polarity 0: low selects component, high composite; 1 inverts this
// - 5-bit signed switch delay, +15 to -15, code 10000 gives -26
// - signed composite-to-component delay, +15 to -16, default 0
// - 3-bit signed luma-versus-chroma delay, +3 to -4, default 0
// - 4-bit coring limit in steps of 4, 0 to 60
// - 4-bit transient gain in sixteenths, 0 to 15/16
// - contrast bit 0: gain n/64-1 (n>=64); bit 1: gain n/128
// - contrast range extension touches composite and S-Video only
// - brightness codes 0,1,3,7,F scale composite and S-Video brightness by 1,2,4,8,16
`ifndef VSSCC_CFG_SVH
`define VSSCC_CFG_SVH
// register indices; the byte address is four times the index
`define VSSCC_IDX_VB_LO   6'h24
`define VSSCC_IDX_VB_HI   6'h25
`define VSSCC_IDX_SYNC    6'h26
`define VSSCC_IDX_FV      6'h27
`define VSSCC_IDX_FS_CTL  6'h28
`define VSSCC_IDX_FS_DLY  6'h2a
`define VSSCC_IDX_SC_DLY  6'h2c
`define VSSCC_IDX_CTI_DLY 6'h2d
`define VSSCC_IDX_CTI_CTL 6'h2e
`define VSSCC_IDX_RANGE   6'h2f
// reset values
`define VSSCC_RST_VB_LO   8'h15
`define VSSCC_VB_525      10'h015
`define VSSCC_VB_625      10'h017
`define VSSCC_RST_FS_CTL  8'hcc
// writable bits of the fast-switch control byte
`define VSSCC_FS_CTL_MASK 8'he5
// field positions
`define VSSCC_FS_POL_BIT  0
`define VSSCC_FS_EDGE_BIT 2
`define VSSCC_RNG_CON_BIT 4
// code printed for the most negative switch delay
`define VSSCC_FS_DLY_MIN  6'h26
`define VSSCC_CON_OFFSET  10'h080
`endif

// ---- vsscc_pkg.sv ----
// types of the configuration bank
package vsscc_pkg;
  typedef struct packed {
    logic [7:0] vb_low_r;
    logic [9:0] vb_stop_r;
    logic       vb_user_r;
    logic [7:0] sync_off_r;
    logic [7:0] fv_off_r;
    logic [7:0] fs_ctl_r;
    logic [4:0] fs_dly_r;
    logic [4:0] sc_dly_r;
    logic [2:0] cti_dly_r;
    logic [7:0] cti_ctl_r;
    logic [4:0] range_r;
    logic       ack_r;
    logic [7:0] rdat_r;
    logic       sclk_prev_r;
    logic       fs_samp_r;
    logic       fs_comp_r;
  } vsscc_state_t;
endpackage

// ---- vsscc_top.sv ----
// register bank for vertical blank, embedded sync offsets, fast switch and transient improvement
//
// Local design decision: register access over Wishbone.
`timescale 1ns/1ns
`default_nettype none
`include "vsscc_cfg.svh"
module vsscc_top
  import vsscc_pkg::*;
(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // video status from the decoder
  input  wire logic        standard_625,
  input  wire logic        standard_lines,
  input  wire logic        component_input,
  input  wire logic [7:0]  contrast_n,
  // fast switch pins
  input  wire logic        sampling_clock,
  input  wire logic        fast_switch_select_input,
  // settings towards the video path
  output logic      [9:0]  vertical_blank_window_stop,
  output logic      [7:0]  embedded_line_offset,
  output logic      [7:0]  embedded_field_offset,
  output logic      [2:0]  fast_switch_mode,
  output logic             select_composite,
  output logic      [5:0]  fast_switch_delay_px,
  output logic      [4:0]  composite_delay_px,
  output logic      [2:0]  chroma_transient_improvement_luma_delay,
  output logic      [5:0]  chroma_transient_improvement_coring,
  output logic      [3:0]  chroma_transient_improvement_gain,
  output logic      [9:0]  contrast_gain_q7,
  output logic      [4:0]  brightness_scale
);

  ////////////////////////////////////////////////////////////////////////////
  // reset release through two flip-flops
  logic rst_s1_r;
  logic rst_s2_r;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus decode
  vsscc_state_t st;
  vsscc_state_t nx;
  logic [5:0]   idx;
  logic         req;
  logic         wr;
  logic [7:0]   wd;
  logic [7:0]   rd;

  assign idx = wb_adr_i[7:2];
  assign req = wb_cyc_i & wb_stb_i;
  // a write lands on the edge where the master sees ack
  assign wr  = req & st.ack_r & wb_we_i & wb_sel_i[0];
  assign wd  = wb_dat_i[7:0];

  // read mux; unmapped indices answer zero
  always_comb begin
    case (idx)
      `VSSCC_IDX_VB_LO:   rd = st.vb_low_r;
      `VSSCC_IDX_VB_HI:   rd = {6'h00, st.vb_stop_r[9:8]};
      `VSSCC_IDX_SYNC:    rd = st.sync_off_r;
      `VSSCC_IDX_FV:      rd = st.fv_off_r;
      `VSSCC_IDX_FS_CTL:  rd = st.fs_ctl_r;
      `VSSCC_IDX_FS_DLY:  rd = {3'h0, st.fs_dly_r};
      `VSSCC_IDX_SC_DLY:  rd = {3'h0, st.sc_dly_r};
      `VSSCC_IDX_CTI_DLY: rd = {5'h00, st.cti_dly_r};
      `VSSCC_IDX_CTI_CTL: rd = st.cti_ctl_r;
      `VSSCC_IDX_RANGE:   rd = {3'h0, st.range_r};
      default:            rd = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    nx = st;
    // ack lasts one cycle, so the master may release on the following edge
    nx.ack_r = req & ~st.ack_r;
    if (req & ~st.ack_r) begin
      nx.rdat_r = rd;
    end
    if (wr) begin
      case (idx)
        `VSSCC_IDX_VB_LO: begin
          nx.vb_low_r = wd;
        end
        `VSSCC_IDX_VB_HI: begin
          nx.vb_stop_r = {wd[1:0], st.vb_low_r};
          nx.vb_user_r = 1'b1;
        end
        `VSSCC_IDX_SYNC:    nx.sync_off_r = wd;
        `VSSCC_IDX_FV:      nx.fv_off_r   = wd;
        `VSSCC_IDX_FS_CTL:  nx.fs_ctl_r   = wd & `VSSCC_FS_CTL_MASK;
        `VSSCC_IDX_FS_DLY:  nx.fs_dly_r   = wd[4:0];
        `VSSCC_IDX_SC_DLY:  nx.sc_dly_r   = wd[4:0];
        `VSSCC_IDX_CTI_DLY: nx.cti_dly_r  = wd[2:0];
        `VSSCC_IDX_CTI_CTL: nx.cti_ctl_r  = wd;
        `VSSCC_IDX_RANGE:   nx.range_r    = wd[4:0];
        default: begin
          nx.rdat_r = st.rdat_r;
        end
      endcase
    end
    // fast switch sampled on the chosen edge of the sampling clock
    nx.sclk_prev_r = sampling_clock;
    if (st.fs_ctl_r[`VSSCC_FS_EDGE_BIT]) begin
      if (st.sclk_prev_r & ~sampling_clock) begin
        nx.fs_samp_r = fast_switch_select_input;
      end
    end else begin
      if (~st.sclk_prev_r & sampling_clock) begin
        nx.fs_samp_r = fast_switch_select_input;
      end
    end
    // polarity maps the sampled level onto the path choice
    nx.fs_comp_r = st.fs_samp_r ^ st.fs_ctl_r[`VSSCC_FS_POL_BIT];
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clock or negedge rst_s2_r) begin
    if (!rst_s2_r) begin
      st           <= '0;
      st.vb_low_r  <= `VSSCC_RST_VB_LO;
      st.vb_stop_r <= `VSSCC_VB_525;
      st.fs_ctl_r  <= `VSSCC_RST_FS_CTL & `VSSCC_FS_CTL_MASK;
    end else begin
      st <= nx;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus outputs
  assign wb_ack_o = st.ack_r;
  assign wb_dat_o = {24'h000000, st.rdat_r};

  ////////////////////////////////////////////////////////////////////////////
  // vertical blank stop: the standard default follows the line count until
  // software programs it, after which only reset brings the default back
  assign vertical_blank_window_stop = st.vb_user_r ? st.vb_stop_r :
                                      (standard_625 ? `VSSCC_VB_625 : `VSSCC_VB_525);

  // offsets are meaningless for nonstandard line counts, so they are withheld
  assign embedded_line_offset  = standard_lines ? st.sync_off_r : 8'h00;
  assign embedded_field_offset = standard_lines ? st.fv_off_r : 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // fast switch
  assign fast_switch_mode = st.fs_ctl_r[7:5];
  assign select_composite = st.fs_comp_r;
  // code 10000 keeps its printed value rather than the two's complement -16
  assign fast_switch_delay_px = (st.fs_dly_r == 5'h10) ? `VSSCC_FS_DLY_MIN :
                                {st.fs_dly_r[4], st.fs_dly_r};
  assign composite_delay_px = st.sc_dly_r;

  ////////////////////////////////////////////////////////////////////////////
  // transient improvement
  assign chroma_transient_improvement_luma_delay = st.cti_dly_r;
  assign chroma_transient_improvement_coring = {st.cti_ctl_r[7:4], 2'b00};
  assign chroma_transient_improvement_gain = st.cti_ctl_r[3:0];

  ////////////////////////////////////////////////////////////////////////////
  // contrast gain in 1/128 steps; below n=64 the extended range clamps to 0
  logic       con_ext;
  logic [9:0] con_dbl;
  assign con_ext = ~st.range_r[`VSSCC_RNG_CON_BIT] & ~component_input;
  assign con_dbl = {1'b0, contrast_n, 1'b0};
  always_comb begin
    if (!con_ext) begin
      contrast_gain_q7 = {2'b00, contrast_n};
    end else if (con_dbl < `VSSCC_CON_OFFSET) begin
      contrast_gain_q7 = 10'h000;
    end else begin
      contrast_gain_q7 = con_dbl - `VSSCC_CON_OFFSET;
    end
  end

  // brightness factor; component inputs always run at 1x
  assign brightness_scale = component_input ? 5'h01 :
                            ({1'b0, st.range_r[3:0]} + 5'h01);

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_s2_r);

  ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");
  ack_next_edge_a: assert property (req && !wb_ack_o |=> wb_ack_o)
    else $error("ack not given one cycle after request");
  vb_low_held_a: assert property (wr && idx == `VSSCC_IDX_VB_LO |=> $stable(st.vb_stop_r))
    else $error("low byte write changed stop line");
  vb_high_apply_a: assert property (wr && idx == `VSSCC_IDX_VB_HI |=>
    vertical_blank_window_stop == {$past(wd[1:0]), $past(st.vb_low_r)})
    else $error("stop line not applied on high byte");
  vb_keep_prog_a: assert property ($past(st.vb_user_r) && $stable(st.vb_stop_r) && $changed(standard_625) |->
    $stable(vertical_blank_window_stop))
    else $error("programmed stop line followed standard");
  vb_default_line_a: assert property (!st.vb_user_r |->
    vertical_blank_window_stop == (standard_625 ? 10'h017 : 10'h015))
    else $error("wrong default stop line");
  offset_gate_a: assert property (!standard_lines |->
    embedded_line_offset == 8'h00 && embedded_field_offset == 8'h00)
    else $error("offset applied to nonstandard input");
  fs_rise_samp_a: assert property (!st.fs_ctl_r[2] && !st.sclk_prev_r && sampling_clock
    |=> st.fs_samp_r == $past(fast_switch_select_input))
    else $error("rising edge sample missed");
  fs_fall_samp_a: assert property (st.fs_ctl_r[2] && st.sclk_prev_r && !sampling_clock
    |=> st.fs_samp_r == $past(fast_switch_select_input))
    else $error("falling edge sample missed");
  fs_polarity_a: assert property ($stable(st.fs_ctl_r) |=>
    select_composite == ($past(st.fs_samp_r) ^ $past(st.fs_ctl_r[0])))
    else $error("switch polarity wrong");
  coring_step_a: assert property (chroma_transient_improvement_coring ==
    6'(st.cti_ctl_r[7:4] * 4))
    else $error("coring not in steps of four");
  contrast_ext_a: assert property (con_ext && contrast_n >= 8'h40 |->
    contrast_gain_q7 == 10'(2 * contrast_n - 128))
    else $error("extended contrast gain wrong");
  rsv_zero_a: assert property (wb_ack_o && idx == `VSSCC_IDX_CTI_DLY |->
    wb_dat_o[31:3] == 29'h0)
    else $error("reserved bits read nonzero");

  ////////////////////////////////////////////////////////////////////////////
  // further checks on register updates, read-back and the derived settings

  // once programmed, only reset may bring the standard default back
  vb_user_sticky_a: assert property (st.vb_user_r |=>
    st.vb_user_r)
    else $error("programmed flag dropped");

  // the high byte write is what marks the stop line as programmed
  vb_user_set_a: assert property (wr && idx == `VSSCC_IDX_VB_HI |=>
    st.vb_user_r)
    else $error("high byte write did not mark stop line");

  // the low byte is held in its own register until the high byte arrives
  vb_low_write_a: assert property (wr && idx == `VSSCC_IDX_VB_LO |=>
    st.vb_low_r == $past(wd))
    else $error("low byte not held");

  // only the two stop line bits of the high byte read back
  vb_hi_read_a: assert property (wb_ack_o && !wb_we_i && idx == `VSSCC_IDX_VB_HI |->
    wb_dat_o[31:2] == 30'h0)
    else $error("stop line high byte reserved bits nonzero");

  // standard inputs see the programmed line offset unchanged
  line_offset_pass_a: assert property (standard_lines |->
    embedded_line_offset == st.sync_off_r)
    else $error("line offset not passed");

  // standard inputs see the programmed field offset unchanged
  field_offset_pass_a: assert property (standard_lines |->
    embedded_field_offset == st.fv_off_r)
    else $error("field offset not passed");

  // the line offset register takes the written byte
  sync_write_a: assert property (wr && idx == `VSSCC_IDX_SYNC |=>
    st.sync_off_r == $past(wd))
    else $error("line offset write lost");

  // the field offset register takes the written byte
  fv_write_a: assert property (wr && idx == `VSSCC_IDX_FV |=>
    st.fv_off_r == $past(wd))
    else $error("field offset write lost");

  // with no edge on the sampling clock the captured level must hold
  fs_hold_a: assert property (st.sclk_prev_r == sampling_clock |=>
    $stable(st.fs_samp_r))
    else $error("switch sampled without an edge");

  // in falling-edge mode a rising edge must not sample
  fs_wrong_edge_a: assert property (st.fs_ctl_r[2] && !st.sclk_prev_r && sampling_clock |=>
    $stable(st.fs_samp_r))
    else $error("switch sampled on wrong edge");

  // non-negative switch delays pass straight through
  fs_dly_pos_a: assert property (!st.fs_dly_r[4] |->
    fast_switch_delay_px == {1'b0, st.fs_dly_r})
    else $error("positive switch delay wrong");

  // the most negative code keeps its special value
  fs_dly_min_a: assert property (st.fs_dly_r == 5'h10 |->
    fast_switch_delay_px == `VSSCC_FS_DLY_MIN)
    else $error("minimum switch delay wrong");

  // composite delay follows its register
  sc_dly_pass_a: assert property (1'b1 |->
    composite_delay_px == st.sc_dly_r)
    else $error("composite delay wrong");

  // luma delay follows its register
  cti_dly_pass_a: assert property (1'b1 |->
    chroma_transient_improvement_luma_delay == st.cti_dly_r)
    else $error("luma delay wrong");

  // the coring and gain byte takes the written value
  cti_ctl_write_a: assert property (wr && idx == `VSSCC_IDX_CTI_CTL |=>
    st.cti_ctl_r == $past(wd))
    else $error("transient control write lost");

  // gain is the low nibble in sixteenths
  gain_pass_a: assert property (1'b1 |->
    chroma_transient_improvement_gain == st.cti_ctl_r[3:0])
    else $error("transient gain wrong");

  // normal range: gain is n in 1/128 steps
  contrast_norm_a: assert property (!con_ext |->
    contrast_gain_q7 == {2'b00, contrast_n})
    else $error("normal contrast gain wrong");

  // extended range clamps below n of 64
  contrast_floor_a: assert property (con_ext && contrast_n < 8'h40 |->
    contrast_gain_q7 == 10'h000)
    else $error("extended contrast not clamped");

  // component inputs are never scaled
  comp_bright_a: assert property (component_input |->
    brightness_scale == 5'h01)
    else $error("component brightness scaled");

  // brightness factor is the code plus one
  bright_code_a: assert property (!component_input |->
    brightness_scale == 5'(st.range_r[3:0] + 1))
    else $error("brightness factor wrong");

  // the range register keeps only its five defined bits
  range_write_a: assert property (wr && idx == `VSSCC_IDX_RANGE |=>
    st.range_r == $past(wd[4:0]))
    else $error("range write lost");

  // reserved control bits stay clear whatever is written
  fs_ctl_rsv_a: assert property (1'b1 |->
    (st.fs_ctl_r & ~`VSSCC_FS_CTL_MASK) == 8'h00)
    else $error("reserved switch bits set");

  // registers are one byte wide, so the upper read lanes stay zero
  rdat_high_zero_a: assert property (1'b1 |->
    wb_dat_o[31:8] == 24'h000000)
    else $error("upper read lanes nonzero");

  // a write without the low lane enabled must leave the registers alone
  wr_no_sel_a: assert property (req && st.ack_r && wb_we_i && !wb_sel_i[0] |=>
    $stable(st.sync_off_r) && $stable(st.vb_stop_r))
    else $error("write without lane enable landed");

  // read data is captured on the request edge and presented with ack
  rd_latch_a: assert property (req && !wb_ack_o |=>
    wb_dat_o == {24'h000000, $past(rd)})
    else $error("read data not presented with ack");

  // with no request pending ack stays low
  ack_idle_a: assert property (!req && !wb_ack_o |=>
    !wb_ack_o)
    else $error("ack without request");

endmodule
`default_nettype wire

// ---- video_sync_switch_cti_config_tb_top.sv ----
// self-checking bench for the sync, switch and transient configuration bank
`timescale 1ns/1ns
`default_nettype none
module video_sync_switch_cti_config_tb_top;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, q;
  logic        ack;
  logic        std625 = 1'b0, stdl = 1'b1, comp = 1'b0, sclk = 1'b0, fsin = 1'b0;
  logic [7:0]  con_n = 8'h50, eline, efield;
  logic [9:0]  vbstop, cgain;
  logic [2:0]  fsmode, ldly;
  logic        selc;
  logic [5:0]  fsdly, coring;
  logic [4:0]  cdly, bscale;
  logic [3:0]  gain;
  int          mismatches = 0;
  int          num_checks = 0;
  logic [3:0]  codes [5] = '{4'h0, 4'h1, 4'h3, 4'h7, 4'hf};

  // clock of 20 ns
  always #10 clock = ~clock;

  vsscc_top DUT (.clock(clock), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .standard_625(std625), .standard_lines(stdl), .component_input(comp), .contrast_n(con_n),
    .sampling_clock(sclk), .fast_switch_select_input(fsin), .vertical_blank_window_stop(vbstop),
    .embedded_line_offset(eline), .embedded_field_offset(efield), .fast_switch_mode(fsmode),
    .select_composite(selc), .fast_switch_delay_px(fsdly), .composite_delay_px(cdly),
    .chroma_transient_improvement_luma_delay(ldly), .chroma_transient_improvement_coring(coring),
    .chroma_transient_improvement_gain(gain), .contrast_gain_q7(cgain), .brightness_scale(bscale));

  ////////////////////////////////////////////////////////////////////////////////
  // verdict, reached from the main sequence and from any bus timeout
  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one classic cycle; read data is taken at the ack edge, before that edge's updates land
  task automatic bus(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
    int n;
    @(posedge clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= d;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat;
    if (ack !== 1'b1) begin
      mismatches++;
      summarize();
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, 4'h1, d);
    repeat (2) @(posedge clock);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 4'hf, 32'h0);
    chk(q, exp);
  endtask

  // one sampling-clock transition, then room for the two-edge capture
  task automatic fs_edge(input logic lvl);
    @(posedge clock);
    sclk <= lvl;
    repeat (4) @(posedge clock);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    rd(8'h90, 32'h15);
    rd(8'ha0, 32'hc4);
    chk(vbstop, 10'h015);
    chk(fsmode, 3'h6);
    chk(cgain, 10'h020);
    std625 <= 1'b1;
    repeat (2) @(posedge clock);
    chk(vbstop, 10'h017);
    $display("test reset done");
    // a low byte write alone leaves the stop line unchanged until the high byte arrives
    wr(8'h90, 32'h34);
    chk(vbstop, 10'h017);
    rd(8'h90, 32'h34);
    wr(8'h94, 32'hfd);
    chk(vbstop, 10'h134);
    rd(8'h94, 32'h01);
    std625 <= 1'b0;
    repeat (2) @(posedge clock);
    chk(vbstop, 10'h134);
    $display("test stop line done");
    wr(8'h98, 32'h80);
    wr(8'h9c, 32'h7f);
    chk(eline, 8'h80);
    chk(efield, 8'h7f);
    stdl <= 1'b0;
    repeat (2) @(posedge clock);
    chk(eline, 8'h00);
    chk(efield, 8'h00);
    bus(1'b1, 8'h98, 4'he, 32'h01);
    rd(8'h98, 32'h80);
    $display("test offsets done");
    // falling edge is the reset choice, so a rise alone must not sample
    fsin <= 1'b1;
    fs_edge(1'b1);
    chk(selc, 1'b0);
    fs_edge(1'b0);
    chk(selc, 1'b1);
    wr(8'ha0, 32'hcd);
    rd(8'ha0, 32'hc5);
    fs_edge(1'b1);
    fs_edge(1'b0);
    chk(selc, 1'b0);
    wr(8'ha0, 32'h21);
    chk(fsmode, 3'h1);
    fsin <= 1'b0;
    fs_edge(1'b1);
    chk(selc, 1'b1);
    fsin <= 1'b1;
    fs_edge(1'b0);
    chk(selc, 1'b1);
    $display("test switch done");
    wr(8'ha8, 32'h10);
    chk(fsdly, 6'h26);
    wr(8'ha8, 32'h1f);
    chk(fsdly, 6'h3f);
    wr(8'hb0, 32'hff);
    rd(8'hb0, 32'h1f);
    chk(cdly, 5'h1f);
    wr(8'hb4, 32'hfc);
    rd(8'hb4, 32'h04);
    chk(ldly, 3'h4);
    wr(8'hb8, 32'hf3);
    chk(coring, 6'h3c);
    chk(gain, 4'h3);
    $display("test delays done");
    con_n <= 8'h3f;
    repeat (2) @(posedge clock);
    chk(cgain, 10'h000);
    for (int i = 0; i < 5; i++) begin
      wr(8'hbc, {24'h0, 4'hf, codes[i]});
      rd(8'hbc, {24'h0, 4'h1, codes[i]});
      chk(bscale, 5'd1 << i);
    end
    chk(cgain, 10'h03f);
    comp <= 1'b1;
    wr(8'hbc, 32'h03);
    chk(bscale, 5'h01);
    chk(cgain, 10'h03f);
    $display("test range done");
    rd(8'ha4, 32'h0);
    wr(8'ha4, 32'hff);
    rd(8'ha4, 32'h0);
    $display("test unmapped done");
    // a reset in mid-run must discard the programmed stop line
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    chk(vbstop, 10'h015);
    rd(8'h94, 32'h00);
    $display("test reset again done");
    summarize();
  end
endmodule
`default_nettype wire
